// file: rtl/lic_line_regs.sv
/*
  Line interface status and pulse shape register group, Wishbone slave top.
  Assumes one clock, an asynchronous active-low reset and async line inputs.
*/
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module lic_line_regs
  import lic_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  output logic [DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  input wire logic signal_loss_live,
  input wire logic pattern_lock_live,
  input wire logic [CABLE_W-1:0] cable_attenuation_code,
  output logic [EQC_W-1:0] equalizer_control_field,
  output logic arbitrary_mode,
  output logic [SEG_W-1:0] pulse_segment_one,
  output logic [SEG_W-1:0] pulse_segment_two,
  output logic seg_one_sign,
  output logic [MAG_W-1:0] seg_one_mag,
  output logic seg_two_sign,
  output logic [MAG_W-1:0] seg_two_mag
);

  // ************************************************************
  // Reset release
  // ************************************************************
  logic rst_meta_reg;
  logic rst_n_sync;

  // Async assert, synchronous release avoids recovery hazards
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_sync <= rst_meta_reg;
    end
  end

  // ************************************************************
  // Bus port and line status inputs
  // ************************************************************
  lic_reg_if bus ();

  lic_wb_port u_port (
    .ref_clk(ref_clk),
    .rst_n_sync(rst_n_sync),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .bus(bus)
  );

  logic [FLAG_W-1:0] live_raw;
  logic [FLAG_W-1:0] live_q;
  logic [FLAG_W-1:0] change;

  assign live_raw[BIT_SIGNAL_LOSS] = signal_loss_live;
  assign live_raw[BIT_PATTERN] = pattern_lock_live;

  lic_change_det u_det (
    .ref_clk(ref_clk),
    .rst_n_sync(rst_n_sync),
    .live_raw(live_raw),
    .live_q(live_q),
    .change(change)
  );

  // Multi-bit code is sampled through two flops; the cable attenuation code
  // changes slowly, so a torn sample lasts one cycle at most.
  logic [CABLE_W-1:0] cable_meta_reg;
  logic [CABLE_W-1:0] cable_reg;

  always_ff @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      cable_meta_reg <= RST_CABLE;
      cable_reg <= RST_CABLE;
    end else begin
      cable_meta_reg <= cable_attenuation_code;
      cable_reg <= cable_meta_reg;
    end
  end

  // ************************************************************
  // Address decode
  // ************************************************************
  function automatic logic lic_hit(input logic [IDX_W-1:0] idx,
                                   input logic [IDX_W-1:0] target);
    lic_hit = (idx == target);
  endfunction : lic_hit

  wire wr_lane = bus.wr_stb & bus.lane_ok;
  wire wr_ctrl = wr_lane & lic_hit(bus.index, IDX_LINE_CTRL);
  wire wr_mask = wr_lane & lic_hit(bus.index, IDX_IRQ_MASK);
  wire wr_event = wr_lane & lic_hit(bus.index, IDX_EVENT);
  wire wr_seg_one = wr_lane & lic_hit(bus.index, IDX_SEG_ONE);
  wire wr_seg_two = wr_lane & lic_hit(bus.index, IDX_SEG_TWO);
  wire rd_event = bus.rd_stb & lic_hit(bus.index, IDX_EVENT);

  // ************************************************************
  // Control and pulse shape registers
  // ************************************************************
  logic [EQC_W-1:0] eqc_reg;
  logic [FLAG_W-1:0] mask_reg;
  logic [SEG_W-1:0] seg_one_reg;
  logic [SEG_W-1:0] seg_two_reg;

  always_ff @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      eqc_reg <= RST_EQC;
      mask_reg <= RST_FLAGS;
      seg_one_reg <= RST_SEG;
      seg_two_reg <= RST_SEG;
    end else begin
      if (wr_ctrl) begin
        eqc_reg <= bus.wdata[EQC_W-1:0];
      end
      if (wr_mask) begin
        mask_reg <= bus.wdata[FLAG_W-1:0];
      end
      if (wr_seg_one) begin
        seg_one_reg <= bus.wdata[SEG_W-1:0];
      end
      if (wr_seg_two) begin
        seg_two_reg <= bus.wdata[SEG_W-1:0];
      end
    end
  end

  // ************************************************************
  // Change event flags
  // ************************************************************
  logic [FLAG_W-1:0] flag_reg;
  logic [FLAG_W-1:0] flag_next;
  logic [FLAG_W-1:0] rd_clear;
  logic [FLAG_W-1:0] wr_clear;

  // A read clears only the flags shown in the captured read word
  assign rd_clear = rd_event ? wb_dat_o[FLAG_W-1:0] : RST_FLAGS;
  assign wr_clear = wr_event ? bus.wdata[FLAG_W-1:0] : RST_FLAGS;
  // Set wins over clear so no edge is lost
  assign flag_next = (flag_reg & ~(rd_clear | wr_clear)) | change;

  always_ff @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      flag_reg <= RST_FLAGS;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // ************************************************************
  // Read data
  // ************************************************************
  logic [DAT_W-1:0] rdata;
  logic [DAT_W-1:0] dat_reg;
  logic [DAT_W-1:0] dat_next;

  // Unmapped indices read as zero and ignore writes
  always_comb begin
    rdata = RST_DAT;
    unique case (1'b1)
      lic_hit(bus.index, IDX_LINE_CTRL): rdata[EQC_W-1:0] = eqc_reg;
      lic_hit(bus.index, IDX_IRQ_MASK): rdata[FLAG_W-1:0] = mask_reg;
      lic_hit(bus.index, IDX_LIVE_STAT): rdata[FLAG_W-1:0] = live_q;
      lic_hit(bus.index, IDX_EVENT): rdata[FLAG_W-1:0] = flag_reg;
      lic_hit(bus.index, IDX_CABLE): rdata[CABLE_W-1:0] = cable_reg;
      lic_hit(bus.index, IDX_SEG_ONE): rdata[SEG_W-1:0] = seg_one_reg;
      lic_hit(bus.index, IDX_SEG_TWO): rdata[SEG_W-1:0] = seg_two_reg;
      default: rdata = RST_DAT;
    endcase
  end

  assign dat_next = bus.acc_stb ? rdata : dat_reg;

  always_ff @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      dat_reg <= RST_DAT;
    end else begin
      dat_reg <= dat_next;
    end
  end

  assign wb_dat_o = dat_reg;
  assign wb_ack_o = bus.ack;

  // ************************************************************
  // Interrupt
  // ************************************************************
  logic irq_reg;

  always_ff @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(flag_reg & mask_reg);
    end
  end

  assign irq = irq_reg;

  // ************************************************************
  // Transmit pulse segments
  // ************************************************************
  // Segments only take effect once software picks arbitrary shaping
  wire arb_sel = (eqc_reg == EQC_ARBITRARY);
  lic_seg_t seg_one_f;
  lic_seg_t seg_two_f;
  logic arb_reg;
  logic [SEG_W-1:0] out_one_reg;
  logic [SEG_W-1:0] out_two_reg;
  lic_seg_t f_one_reg;
  lic_seg_t f_two_reg;

  assign seg_one_f = lic_split_seg(arb_sel ? seg_one_reg : RST_SEG);
  assign seg_two_f = lic_split_seg(arb_sel ? seg_two_reg : RST_SEG);

  always_ff @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      arb_reg <= 1'b0;
      out_one_reg <= RST_SEG;
      out_two_reg <= RST_SEG;
      f_one_reg <= RST_SEG;
      f_two_reg <= RST_SEG;
    end else begin
      arb_reg <= arb_sel;
      out_one_reg <= arb_sel ? seg_one_reg : RST_SEG;
      out_two_reg <= arb_sel ? seg_two_reg : RST_SEG;
      f_one_reg <= seg_one_f;
      f_two_reg <= seg_two_f;
    end
  end

  assign equalizer_control_field = eqc_reg;
  assign arbitrary_mode = arb_reg;
  assign pulse_segment_one = out_one_reg;
  assign pulse_segment_two = out_two_reg;
  assign seg_one_sign = f_one_reg.sign;
  assign seg_one_mag = f_one_reg.mag;
  assign seg_two_sign = f_two_reg.sign;
  assign seg_two_mag = f_two_reg.mag;

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_loss_flag_set;
    @(posedge ref_clk) disable iff (!rst_n_sync)
      change[BIT_SIGNAL_LOSS] |=> flag_reg[BIT_SIGNAL_LOSS];
  endproperty
  a_loss_flag_set: assert property (p_loss_flag_set)
    else $error("loss change flag not set");

  property p_lock_flag_set;
    @(posedge ref_clk) disable iff (!rst_n_sync)
      $changed(live_q[BIT_PATTERN]) |-> ##[0:1] flag_reg[BIT_PATTERN];
  endproperty
  a_lock_flag_set: assert property (p_lock_flag_set)
    else $error("pattern change flag not set");

  property p_live_read;
    @(posedge ref_clk) disable iff (!rst_n_sync)
      bus.acc_stb && lic_hit(bus.index, IDX_LIVE_STAT)
      |=> wb_dat_o[BIT_SIGNAL_LOSS] == $past(live_q[BIT_SIGNAL_LOSS]);
  endproperty
  a_live_read: assert property (p_live_read)
    else $error("live loss state misread");

  property p_cable_read;
    @(posedge ref_clk) disable iff (!rst_n_sync)
      bus.acc_stb && lic_hit(bus.index, IDX_CABLE)
      |=> wb_dat_o == {26'h0, $past(cable_reg)} ##1 wb_ack_o == 1'b0;
  endproperty
  a_cable_read: assert property (p_cable_read)
    else $error("cable code misread");

  property p_seg_one_out;
    @(posedge ref_clk) disable iff (!rst_n_sync)
      wr_seg_one && arb_sel && !wr_ctrl
      |=> ##1 pulse_segment_one == $past(bus.wdata[SEG_W-1:0], 2);
  endproperty
  a_seg_one_out: assert property (p_seg_one_out)
    else $error("segment one not applied");

  property p_seg_two_idle;
    @(posedge ref_clk) disable iff (!rst_n_sync)
      !arb_sel |=> pulse_segment_two == RST_SEG && !arbitrary_mode;
  endproperty
  a_seg_two_idle: assert property (p_seg_two_idle)
    else $error("segment two active outside arbitrary mode");

  property p_seg_two_out;
    @(posedge ref_clk) disable iff (!rst_n_sync)
      arb_sel |=> pulse_segment_two == $past(seg_two_reg);
  endproperty
  a_seg_two_out: assert property (p_seg_two_out)
    else $error("segment two not applied");

  property p_sign_mag;
    @(posedge ref_clk) disable iff (!rst_n_sync)
      arb_sel |=> seg_one_sign == $past(seg_one_reg[SEG_W-1])
        && seg_one_mag == $past(seg_one_reg[MAG_W-1:0])
        && seg_two_sign == $past(seg_two_reg[SEG_W-1])
        && seg_two_mag == $past(seg_two_reg[MAG_W-1:0]);
  endproperty
  a_sign_mag: assert property (p_sign_mag)
    else $error("sign or magnitude split wrong");

  property p_read_keeps_new;
    @(posedge ref_clk) disable iff (!rst_n_sync)
      rd_event && change[BIT_SIGNAL_LOSS] |=> flag_reg[BIT_SIGNAL_LOSS];
  endproperty
  a_read_keeps_new: assert property (p_read_keeps_new)
    else $error("event lost during read");

  property p_read_clears;
    @(posedge ref_clk) disable iff (!rst_n_sync)
      rd_event && wb_dat_o[BIT_PATTERN] && !change[BIT_PATTERN]
      |=> !flag_reg[BIT_PATTERN];
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("captured flag not cleared");

  property p_ack_pulse;
    @(posedge ref_clk) disable iff (!rst_n_sync)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack not a single cycle");

  property p_irq;
    @(posedge ref_clk) disable iff (!rst_n_sync)
      ##1 irq == |($past(flag_reg) & $past(mask_reg));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt level wrong");

  c_read_event: cover property (@(posedge ref_clk) disable iff (!rst_n_sync)
    rd_event && wb_dat_o[BIT_SIGNAL_LOSS]);
  c_arb_mode: cover property (@(posedge ref_clk) disable iff (!rst_n_sync)
    $rose(arbitrary_mode));
  c_irq: cover property (@(posedge ref_clk) disable iff (!rst_n_sync)
    $rose(irq));
  c_race: cover property (@(posedge ref_clk) disable iff (!rst_n_sync)
    rd_event && |change);

endmodule : lic_line_regs
`default_nettype wire

// file: shared/lic_pkg.sv
/*
  Constants and types of the line interface status and pulse register group.
  Assumes a 32-bit classic Wishbone bus with word-aligned registers.
*/
`default_nettype none
package lic_pkg;
  // ************************************************************
  // Bus geometry
  // ************************************************************
  localparam int ADR_W = 16;
  localparam int DAT_W = 32;
  localparam int IDX_W = 14;
  localparam int IDX_LSB = 2;
  localparam int REG_W = 8;
  localparam int SEL_LANE = 0;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [IDX_W-1:0] IDX_LINE_CTRL = 14'h0F00;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 14'h0F04;
  localparam logic [IDX_W-1:0] IDX_LIVE_STAT = 14'h0F05;
  localparam logic [IDX_W-1:0] IDX_EVENT = 14'h0F06;
  localparam logic [IDX_W-1:0] IDX_CABLE = 14'h0F07;
  localparam logic [IDX_W-1:0] IDX_SEG_ONE = 14'h0F08;
  localparam logic [IDX_W-1:0] IDX_SEG_TWO = 14'h0F09;

  // ************************************************************
  // Fields and reset values
  // ************************************************************
  localparam int FLAG_W = 2;
  localparam int BIT_PATTERN = 0;
  localparam int BIT_SIGNAL_LOSS = 1;
  localparam int EQC_W = 5;
  localparam int CABLE_W = 6;
  localparam int SEG_W = 7;
  localparam int MAG_W = 6;
  localparam logic [EQC_W-1:0] RST_EQC = 5'h00;
  localparam logic [FLAG_W-1:0] RST_FLAGS = 2'h0;
  localparam logic [SEG_W-1:0] RST_SEG = 7'h00;
  localparam logic [CABLE_W-1:0] RST_CABLE = 6'h00;
  localparam logic [DAT_W-1:0] RST_DAT = 32'h0000_0000;
  // Equalizer code that selects arbitrary pulse shaping
  localparam logic [EQC_W-1:0] EQC_ARBITRARY = 5'h1F;

  typedef struct packed {
    logic sign;
    logic [MAG_W-1:0] mag;
  } lic_seg_t;

  function automatic lic_seg_t lic_split_seg(input logic [SEG_W-1:0] v);
    lic_split_seg = v;
  endfunction : lic_split_seg
endpackage : lic_pkg
`default_nettype wire

// file: shared/lic_reg_if.sv
/*
  Decoded register access strobes between the bus port and the register core.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface lic_reg_if;
  import lic_pkg::*;
  logic acc_stb;
  logic rd_stb;
  logic wr_stb;
  logic lane_ok;
  logic ack;
  logic [IDX_W-1:0] index;
  logic [DAT_W-1:0] wdata;
  modport port (output acc_stb, rd_stb, wr_stb, lane_ok, ack, index, wdata);
  modport core (input acc_stb, rd_stb, wr_stb, lane_ok, ack, index, wdata);
endinterface : lic_reg_if
`default_nettype wire

// file: rtl/lic_wb_port.sv
/*
  Classic Wishbone slave front end: registered ack, one wait state.
  Assumes the master holds its request until it samples ack.
*/
`timescale 1ns/1ns
`default_nettype none
module lic_wb_port
  import lic_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n_sync,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  lic_reg_if.port bus
);
  logic ack_reg;
  logic ack_next;
  wire req = wb_cyc_i & wb_stb_i;

  // Ack drops after one cycle so back-to-back cycles see a gap
  assign ack_next = req & ~ack_reg;
  assign bus.ack = ack_reg;
  assign bus.acc_stb = req & ~ack_reg;
  assign bus.rd_stb = req & ack_reg & ~wb_we_i;
  assign bus.wr_stb = req & ack_reg & wb_we_i;
  assign bus.lane_ok = wb_sel_i[SEL_LANE];
  assign bus.index = wb_adr_i[ADR_W-1:IDX_LSB];
  assign bus.wdata = wb_dat_i;

  always_ff @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
    end
  end
endmodule : lic_wb_port
`default_nettype wire

// file: rtl/lic_change_det.sv
/*
  Two-flop synchroniser and change detector for the live line status bits.
  Assumes inputs are asynchronous levels from the receive line logic.
*/
`timescale 1ns/1ns
`default_nettype none
module lic_change_det
  import lic_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n_sync,
  input wire logic [FLAG_W-1:0] live_raw,
  output logic [FLAG_W-1:0] live_q,
  output logic [FLAG_W-1:0] change
);
  logic [FLAG_W-1:0] meta_reg;
  logic [FLAG_W-1:0] sync_reg;
  logic [FLAG_W-1:0] prev_reg;

  assign live_q = sync_reg;
  assign change = sync_reg ^ prev_reg;

  always_ff @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      meta_reg <= RST_FLAGS;
      sync_reg <= RST_FLAGS;
      prev_reg <= RST_FLAGS;
    end else begin
      meta_reg <= live_raw;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end
endmodule : lic_change_det
`default_nettype wire

// file: testbench/tb_lic_line_regs.sv
/*
  Self-checking bench for the line interface status and pulse register group.
  Assumes the design package, the access interface and the rtl files are
  compiled first; drives the Wishbone port and line inputs directly.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_lic_line_regs
  import lic_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_b;
  logic cyc;
  logic stb;
  logic we;
  logic [ADR_W-1:0] adr;
  logic [3:0] sel;
  logic [DAT_W-1:0] wdat;
  logic [DAT_W-1:0] rdat;
  logic ack;
  logic irq;
  logic loss_live;
  logic lock_live;
  logic [CABLE_W-1:0] cable;
  logic [EQC_W-1:0] eqc;
  logic arb;
  logic [SEG_W-1:0] seg1;
  logic [SEG_W-1:0] seg2;
  logic s1s;
  logic s2s;
  logic [MAG_W-1:0] s1m;
  logic [MAG_W-1:0] s2m;
  logic [DAT_W-1:0] ra;
  logic [DAT_W-1:0] rb;
  int num_errors = 0;
  int checks = 0;

  always #2 ref_clk = ~ref_clk;

  lic_line_regs dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq(irq), .signal_loss_live(loss_live), .pattern_lock_live(lock_live),
    .cable_attenuation_code(cable), .equalizer_control_field(eqc),
    .arbitrary_mode(arb), .pulse_segment_one(seg1), .pulse_segment_two(seg2),
    .seg_one_sign(s1s), .seg_one_mag(s1m), .seg_two_sign(s2s), .seg_two_mag(s2m)
  );

  // ************************************************************
  // Bus and check tasks
  // ************************************************************
  task automatic chk(input string what, input logic [DAT_W-1:0] seen,
                     input logic [DAT_W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Outputs are read right after the edge, before the design's updates land
  task automatic bus(input logic wr_en, input logic [IDX_W-1:0] idx,
                     input logic [DAT_W-1:0] d, input logic [3:0] s,
                     output logic [DAT_W-1:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr_en;
    adr <= {idx, 2'h0};
    wdat <= d;
    sel <= s;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      num_errors++;
      $display("[ERR] ack expected 1 seen %b", ack);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [DAT_W-1:0] d);
    logic [DAT_W-1:0] q;
    bus(1'b1, idx, d, 4'h1, q);
  endtask : wr

  task automatic rd(input logic [IDX_W-1:0] idx, output logic [DAT_W-1:0] q);
    bus(1'b0, idx, 32'h0000_0000, 4'h1, q);
  endtask : rd

  task automatic rchk(input string what, input logic [IDX_W-1:0] idx,
                      input logic [DAT_W-1:0] exp);
    logic [DAT_W-1:0] q;
    rd(idx, q);
    chk(what, q, exp);
  endtask : rchk

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wait_clk

  task automatic conclude;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    rst_b <= 1'b0;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    adr <= 16'h0000;
    sel <= 4'h0;
    wdat <= 32'h0000_0000;
    loss_live <= 1'b0;
    lock_live <= 1'b0;
    cable <= 6'h2D;
    wait_clk(3);
    rst_b <= 1'b1;
    wait_clk(3);
    rchk("seg_one_rst", IDX_SEG_ONE, 32'h0000_0000);
    rchk("seg_two_rst", IDX_SEG_TWO, 32'h0000_0000);
    rchk("event_rst", IDX_EVENT, 32'h0000_0000);
    rchk("ctrl_rst", IDX_LINE_CTRL, 32'h0000_0000);
    // Cable code, including a write attempt to the read-only word
    rchk("cable_a", IDX_CABLE, 32'h0000_002D);
    cable <= 6'h12;
    wait_clk(4);
    wr(IDX_CABLE, 32'h0000_003F);
    rchk("cable_b", IDX_CABLE, 32'h0000_0012);
    // Segments; a write without lane 0 must not land
    wr(IDX_SEG_ONE, 32'h0000_005A);
    wr(IDX_SEG_TWO, 32'h0000_00FF);
    bus(1'b1, IDX_SEG_ONE, 32'h0000_0011, 4'h2, ra);
    rchk("seg_one", IDX_SEG_ONE, 32'h0000_005A);
    rchk("seg_two", IDX_SEG_TWO, 32'h0000_007F);
    chk("pulse_one_off", {25'h0, seg1}, 32'h0000_0000);
    wr(IDX_LINE_CTRL, 32'h0000_001F);
    wait_clk(3);
    chk("eqc", {27'h0, eqc}, 32'h0000_001F);
    chk("arb_on", {31'h0, arb}, 32'h0000_0001);
    chk("pulse_one", {25'h0, seg1}, 32'h0000_005A);
    chk("pulse_two", {25'h0, seg2}, 32'h0000_007F);
    chk("one_sign", {31'h0, s1s}, 32'h0000_0001);
    chk("one_mag", {26'h0, s1m}, 32'h0000_001A);
    chk("two_sign", {31'h0, s2s}, 32'h0000_0001);
    chk("two_mag", {26'h0, s2m}, 32'h0000_003F);
    wr(IDX_SEG_ONE, 32'h0000_0025);
    wait_clk(3);
    chk("one_sign_pos", {31'h0, s1s}, 32'h0000_0000);
    chk("one_mag_pos", {26'h0, s1m}, 32'h0000_0025);
    wr(IDX_LINE_CTRL, 32'h0000_001E);
    wait_clk(3);
    chk("arb_off", {31'h0, arb}, 32'h0000_0000);
    chk("pulse_one_off2", {25'h0, seg1}, 32'h0000_0000);
    // Unmapped place reads zero
    wr(14'h0F0A, 32'h0000_00FF);
    rchk("unmapped", 14'h0F0A, 32'h0000_0000);
    // Change events, live status and clear on read
    loss_live <= 1'b1;
    wait_clk(6);
    rchk("live_loss", IDX_LIVE_STAT, 32'h0000_0002);
    rchk("ev_loss", IDX_EVENT, 32'h0000_0002);
    rchk("ev_loss_clr", IDX_EVENT, 32'h0000_0000);
    lock_live <= 1'b1;
    wait_clk(6);
    rchk("live_both", IDX_LIVE_STAT, 32'h0000_0003);
    rchk("ev_lock", IDX_EVENT, 32'h0000_0001);
    rchk("ev_lock_clr", IDX_EVENT, 32'h0000_0000);
    // Interrupt: raise, clear by write of one, then masked
    wr(IDX_IRQ_MASK, 32'h0000_0003);
    loss_live <= 1'b0;
    wait_clk(6);
    chk("irq_up", {31'h0, irq}, 32'h0000_0001);
    wr(IDX_EVENT, 32'h0000_0002);
    wait_clk(2);
    chk("irq_w1c", {31'h0, irq}, 32'h0000_0000);
    rchk("ev_w1c", IDX_EVENT, 32'h0000_0000);
    wr(IDX_IRQ_MASK, 32'h0000_0001);
    loss_live <= 1'b1;
    wait_clk(6);
    chk("irq_masked", {31'h0, irq}, 32'h0000_0000);
    rchk("ev_masked", IDX_EVENT, 32'h0000_0002);
    lock_live <= 1'b0;
    wait_clk(6);
    chk("irq_lock", {31'h0, irq}, 32'h0000_0001);
    rchk("ev_lock2", IDX_EVENT, 32'h0000_0001);
    wait_clk(2);
    chk("irq_rd_clr", {31'h0, irq}, 32'h0000_0000);
    // Changes landing around the read: each must be reported exactly once
    for (int d = 0; d < 6; d++) begin
      loss_live <= ~loss_live;
      lock_live <= ~lock_live;
      wait_clk(d);
      rd(IDX_EVENT, ra);
      wait_clk(6);
      rd(IDX_EVENT, rb);
      chk("ev_once_any", (ra | rb) & 32'h0000_0003, 32'h0000_0003);
      chk("ev_once_dup", (ra & rb) & 32'h0000_0003, 32'h0000_0000);
    end
    conclude();
  end

  // Whole run is well under a thousand cycles
  initial begin
    #40000;
    num_errors++;
    $display("[ERR] run expected finished seen timeout");
    conclude();
  end
endmodule : tb_lic_line_regs
`default_nettype wire
